// ---- hdl/ssi_pkg.sv ----
// Shared constants and types for the SSI position link
package ssi_pkg;

    //****************************************************************
    // Clocking
    //****************************************************************
    localparam int CLK_HZ   = 25_000_000;         // System clock rate
    localparam int CLK_NS   = 40;                 // System clock period

    //****************************************************************
    // Word layout
    //****************************************************************
    localparam int ST_BITS   = 13;                // Singleturn step bits
    localparam int MT_BITS   = 12;                // Multiturn revolution bits
    localparam int WORD_BITS = ST_BITS + MT_BITS; // Total resolution n

    //****************************************************************
    // Timing
    //****************************************************************
    localparam int TM_NS    = 20_000;             // Monoflop time
    localparam int TM_CYC   = (TM_NS + CLK_NS - 1) / CLK_NS;
    localparam int TP_NS    = 30_000;             // Controller clock pause
    localparam int TP_CYC   = (TP_NS + CLK_NS - 1) / CLK_NS;
    localparam int BAUD_HZ  = 100_000;            // Controller bit rate
    localparam int HALF_CYC = CLK_HZ / (2 * BAUD_HZ);
    localparam int HOLD_CYC = 2;                  // Link re-arm pulse length
    localparam int FIFO_DEPTH = 4;                // Received word buffer

    //****************************************************************
    // Reset values
    //****************************************************************
    localparam logic IDLE_LEVEL = 1'h1;           // Lines rest high

    //****************************************************************
    // Controller states
    //****************************************************************
    typedef enum logic [1:0] {
        CT_IDLE,
        CT_LOW,
        CT_HIGH,
        CT_PAUSE
    } ctrl_state_t;

endpackage

// ---- hdl/ssi_link_if.sv ----
// Link wires between the encoder and the controller
`timescale 1ns/10ps
interface ssi_link_if;
    logic clk_p;   // Clock plus line, from the controller
    logic clk_n;   // Clock minus line
    logic data_p;  // Data plus line, from the encoder
    logic data_n;  // Data minus line

    // Complementary lines of the differential pairs
    assign clk_n  = ~clk_p;
    assign data_n = ~data_p;

    modport device (input clk_p, output data_p);
    modport ctrl   (output clk_p, input data_p);
endinterface

// ---- hdl/stream_fifo.sv ----
// Small valid/ready FIFO with parameterised width and depth
`timescale 1ns/10ps
module stream_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    // Depth must be a power of two, at least two
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("stream_fifo: DEPTH must be a power of two >= 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;  // Storage
        logic [AW:0]             wr;   // Write pointer, wrap bit on top
        logic [AW:0]             rd;   // Read pointer, wrap bit on top
    } fifo_t;

    fifo_t st;       // Registered state
    fifo_t next_st;  // Next state
    logic  full;     // No room left
    logic  empty;    // Nothing stored

    // Wrap bits differ and indices match when full
    assign empty     = st.wr == st.rd;
    assign full      = (st.wr[AW] != st.rd[AW]) && (st.wr[AW-1:0] == st.rd[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = st.mem[st.rd[AW-1:0]];

    // Pointer and storage update
    always_comb begin
        next_st = st;
        if (in_valid && !full) begin
            next_st.mem[st.wr[AW-1:0]] = in_data;
            next_st.wr = st.wr + 1'b1;
        end
        if (out_ready && !empty) begin
            next_st.rd = st.rd + 1'b1;
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ---- hdl/ssi_encoder.sv ----
// SSI encoder end: captures a position word and shifts it out on the link clock
`timescale 1ns/10ps
//****************************************************************
// Summary of operation
// R1 - Clock and data lines idle high
// R2 - First clock fall captures current word; code captures the word staged during the last re-arm pulse
// R3 - First rising edge drives the MSB
// R4 - Each later rise drives next lower bit
// R5 - After LSB data low until monoflop ends
// R6 - Controller waits for data high or pause
// R7 - Last clock fall restarts the monoflop
// R8 - Controller clock period below monoflop time
// R9 - Word carries exactly n bits
// R10 - Unbroken clocking resends the same word
// R11 - Pulse n+1 decides on a repeat
// R12 - Late pulse n+1 gets a fresh word
// R13 - Controller may compare repeated copies
// R14 - Swapped clock lines shift the word
// R15 - Controller samples between rises, MSB first
//****************************************************************
module ssi_encoder
    import ssi_pkg::*;
#(
    parameter int N_BITS = WORD_BITS,
    parameter int TM     = TM_CYC
) (
    // Link side
    ssi_link_if.device              link,
    // System clock and reset
    input  wire logic               sys_clk,
    input  wire logic               nrst,
    // Position source
    input  wire logic [N_BITS-1:0]  pos_word,
    // Status
    output logic                    mono_busy
);
    //****************************************************************
    // Widths and checks
    //****************************************************************
    localparam int CW  = $clog2(N_BITS + 1);  // Rise counter width
    localparam int TMW = $clog2(TM + 1);      // Monoflop counter width

    // Need a real word and a monoflop longer than the re-arm pulse
    if (N_BITS < 2 || TM <= HOLD_CYC) begin : g_chk
        $error("ssi_encoder: N_BITS >= 2 and TM > HOLD_CYC required");
    end

    //****************************************************************
    // System-domain state
    //****************************************************************
    typedef struct packed {
        logic              s1;        // Fall toggle, first sync stage
        logic              s2;        // Fall toggle, second sync stage
        logic              s3;        // Previous synced toggle
        logic [TMW-1:0]    mono;      // Monoflop countdown
        logic              busy;      // Monoflop running
        logic [1:0]        hold;      // Re-arm pulse countdown
        logic              link_hold; // Re-arm pulse, glitch free
        logic [N_BITS-1:0] tx;        // Word offered to the next burst
    } enc_sys_t;

    //****************************************************************
    // Link-domain state, falling edge
    //****************************************************************
    typedef struct packed {
        logic              started;   // Word captured in this frame
        logic [N_BITS-1:0] word;      // Captured word
    } enc_fall_t;

    //****************************************************************
    // Link-domain state, rising edge
    //****************************************************************
    typedef struct packed {
        logic [CW-1:0]     cnt;       // Rises seen in the current word
        logic              data;      // Serial data output
    } enc_rise_t;

    // Reset values; the re-arm pulse also fires right after reset
    localparam enc_sys_t SYS_RST = '{
        s1: 1'h0, s2: 1'h0, s3: 1'h0, mono: '0, busy: 1'h0,
        hold: 2'(HOLD_CYC), link_hold: 1'h1, tx: '0
    };
    localparam enc_rise_t RISE_RST = '{cnt: '0, data: IDLE_LEVEL};

    enc_sys_t  s;          // System-domain registers
    enc_sys_t  next_s;     // System-domain next value
    enc_fall_t f;          // Falling-edge registers
    enc_fall_t next_f;     // Falling-edge next value
    enc_rise_t r;          // Rising-edge registers
    enc_rise_t next_r;     // Rising-edge next value
    logic      fall_tog;   // Flips on every clock fall
    logic      link_nrst;  // Reset of the link-side logic

    //****************************************************************
    // Link reset
    //****************************************************************
    // The re-arm pulse fires right after reset or after a full monoflop of link silence,
    // so the link clock is standing still when this reset toggles.
    assign link_nrst = nrst & ~s.link_hold;

    //****************************************************************
    // Monoflop and word staging, system clock
    //****************************************************************
    always_comb begin
        next_s      = s;
        next_s.s1   = fall_tog;
        next_s.s2   = s.s1;
        next_s.s3   = s.s2;
        next_s.hold = (s.hold != 2'h0) ? s.hold - 2'h1 : 2'h0;
        // R7 restart on fall
        if (s.s2 != s.s3) begin
            next_s.mono = TMW'(TM);
            next_s.busy = 1'h1;
        end else if (s.busy) begin
            // Count down; expiry fires the re-arm pulse
            next_s.mono = s.mono - 1'b1;
            if (s.mono == TMW'(1)) begin
                next_s.busy = 1'h0;
                next_s.hold = 2'(HOLD_CYC);
            end
        end
        next_s.link_hold = next_s.hold != 2'h0;
        // R12 fresh word staging
        if (s.hold != 2'h0) begin
            next_s.tx = pos_word;
        end
    end

    // System-domain register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s <= SYS_RST;
        end else begin
            s <= next_s;
        end
    end

    //****************************************************************
    // Capture, link clock falling edge
    //****************************************************************
    always_comb begin
        next_f = f;
        // R2 capture at first fall
        if (!f.started) begin
            next_f.started = 1'h1;
            next_f.word    = s.tx;
        end
        // R10 no recapture while clocking runs
    end

    // Captured word, cleared by system reset or by the re-arm pulse
    always_ff @(negedge link.clk_p or negedge link_nrst) begin
        if (!link_nrst) begin
            f <= '0;
        end else begin
            f <= next_f;
        end
    end

    // Event toggle to the system domain; kept out of the re-arm reset
    // so that clearing it cannot look like a fresh clock fall.
    always_ff @(negedge link.clk_p or negedge nrst) begin
        if (!nrst) begin
            fall_tog <= 1'h0;
        end else begin
            fall_tog <= ~fall_tog;
        end
    end

    //****************************************************************
    // Shift out, link clock rising edge
    //****************************************************************
    // An inverted clock pair swaps which edges capture and which shift,
    // so the word comes out offset by a bit position.
    // R14 swapped pair offsets word
    always_comb begin
        next_r = r;
        // R5 low after the LSB
        if (r.cnt == CW'(N_BITS)) begin
            next_r.data = 1'h0;
            // R11 wrap on pulse n+1
            next_r.cnt  = '0;
        end else begin
            // R3 MSB first, R4 then lower bits
            next_r.data = f.word[CW'(N_BITS - 1) - r.cnt];
            next_r.cnt  = r.cnt + 1'b1;
        end
    end

    // R1 idle high from reset
    always_ff @(posedge link.clk_p or negedge link_nrst) begin
        if (!link_nrst) begin
            r <= RISE_RST;
        end else begin
            r <= next_r;
        end
    end

    //****************************************************************
    // Outputs
    //****************************************************************
    // R9 n bits per word
    assign link.data_p = r.data;
    assign mono_busy   = s.busy;

endmodule

// ---- hdl/ssi_controller.sv ----
// SSI controller end: clock bursts, word assembly and a receive FIFO
`timescale 1ns/10ps
module ssi_controller
    import ssi_pkg::*;
#(
    parameter int N_BITS = WORD_BITS,
    parameter int HALF   = HALF_CYC,
    parameter int TP     = TP_CYC,
    parameter int DEPTH  = FIFO_DEPTH
) (
    // Link side
    ssi_link_if.ctrl                link,
    // System clock and reset
    input  wire logic               sys_clk,
    input  wire logic               nrst,
    // Control
    input  wire logic               run,
    input  wire logic               ring_mode,
    // Received words
    output logic                    word_valid,
    input  wire logic               word_ready,
    output logic [N_BITS-1:0]       word_data,
    output logic                    word_mismatch,
    // Status
    output logic                    busy
);
    //****************************************************************
    // Widths and checks
    //****************************************************************
    localparam int HW = $clog2(HALF + 1);     // Half-period counter
    localparam int CW = $clog2(N_BITS + 2);   // Fall counter in a word
    localparam int PW = $clog2(TP + 1);       // Pause counter

    // Sampling needs the data synchroniser to settle within a bit
    if (HALF < 3 || N_BITS < 2 || TP < 1 || 2 * HALF >= TM_CYC) begin : g_chk
        $error("ssi_controller: HALF >= 3 and clock period below monoflop");
    end

    typedef struct packed {
        logic              d1;     // Data line, first sync stage
        logic              d2;     // Data line, second sync stage
        ctrl_state_t       st;     // Burst state
        logic [HW-1:0]     half;   // Cycles in the current half period
        logic [CW-1:0]     w;      // Fall number within the word
        logic              copy;   // Second copy in ring slide
        logic              clk;    // Clock line output
        logic [N_BITS-1:0] sh;     // Assembling word
        logic [N_BITS-1:0] first;  // First copy, for comparison
        logic              mism;   // Copies differed
        logic              push;   // Word ready for the FIFO
        logic [PW-1:0]     pause;  // Clock pause counter
    } ctrl_t;

    localparam ctrl_t CTRL_RST = '{
        d1: IDLE_LEVEL, d2: IDLE_LEVEL, st: CT_IDLE, half: '0, w: '0,
        copy: 1'h0, clk: IDLE_LEVEL, sh: '0, first: '0, mism: 1'h0,
        push: 1'h0, pause: '0
    };

    ctrl_t c;          // Registered state
    ctrl_t next_c;     // Next state
    logic  fifo_room;  // FIFO can take one more word

    //****************************************************************
    // Burst sequencer
    //****************************************************************
    always_comb begin
        next_c      = c;
        next_c.d1   = link.data_p;
        next_c.d2   = c.d1;
        next_c.push = 1'h0;
        unique case (c.st)
            CT_IDLE: begin
                // R1 clock rests high
                next_c.clk  = IDLE_LEVEL;
                next_c.half = (c.half == HW'(HALF - 1)) ? c.half : c.half + 1'b1;
                // Start only with room, so the push is never refused
                if (run && fifo_room && c.half == HW'(HALF - 1)) begin
                    next_c.st   = CT_LOW;
                    next_c.clk  = 1'h0;
                    next_c.half = '0;
                    next_c.w    = CW'(1);
                    next_c.copy = 1'h0;
                end
            end
            CT_LOW: begin
                if (c.half == HW'(HALF - 1)) begin
                    next_c.half = '0;
                    next_c.clk  = 1'h1;
                    next_c.st   = CT_HIGH;
                    // R15 sample before rise
                    if (c.w >= CW'(2)) begin
                        next_c.sh = {c.sh[N_BITS-2:0], c.d2};
                    end
                end else begin
                    next_c.half = c.half + 1'b1;
                end
            end
            CT_HIGH: begin
                if (c.half != HW'(HALF - 1)) begin
                    next_c.half = c.half + 1'b1;
                end else if (c.w != CW'(N_BITS + 1)) begin
                    next_c.half = '0;
                    next_c.w    = c.w + 1'b1;
                    next_c.clk  = 1'h0;
                    next_c.st   = CT_LOW;
                end else if (ring_mode && !c.copy) begin
                    // R13 keep clocking for a copy
                    next_c.half  = '0;
                    next_c.copy  = 1'h1;
                    next_c.first = c.sh;
                    next_c.w     = CW'(1);
                    next_c.clk   = 1'h0;
                    next_c.st    = CT_LOW;
                end else begin
                    next_c.half  = '0;
                    next_c.push  = 1'h1;
                    next_c.mism  = c.copy && (c.sh != c.first);
                    next_c.pause = '0;
                    next_c.st    = CT_PAUSE;
                end
            end
            CT_PAUSE: begin
                next_c.pause = c.pause + 1'b1;
                // R6 wait for data high or pause
                if (c.d2 || c.pause == PW'(TP - 1)) begin
                    next_c.st = CT_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            c <= CTRL_RST;
        end else begin
            c <= next_c;
        end
    end

    //****************************************************************
    // Receive buffer
    //****************************************************************
    stream_fifo #(
        .W     (N_BITS + 1),
        .DEPTH (DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .in_valid  (c.push),
        .in_ready  (fifo_room),
        .in_data   ({c.mism, c.sh}),
        .out_valid (word_valid),
        .out_ready (word_ready),
        .out_data  ({word_mismatch, word_data})
    );

    //****************************************************************
    // Outputs
    //****************************************************************
    // R8 period fixed below monoflop
    assign link.clk_p = c.clk;
    assign busy       = c.st != CT_IDLE;

endmodule

// ---- sim/ssi_link_sva.sv ----
// Assertion checker watching the SSI link wires
`timescale 1ns/10ps
module ssi_link_sva #(
    parameter int TM   = 40,
    parameter int HALF = 4,
    parameter int TP   = 60
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic nrst,
    // Link wires
    input  wire logic clk_p,
    input  wire logic data_p
);
    //****************************************************************
    // Helper counter
    //****************************************************************
    logic [11:0] hi_cnt;    // Cycles with clock high, saturating

    // Saturation keeps long idle spans from wrapping to small values
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hi_cnt <= 12'h000;
        end else if (!clk_p) begin
            hi_cnt <= 12'h000;
        end else if (hi_cnt != 12'hfff) begin
            hi_cnt <= hi_cnt + 12'h001;
        end
    end

    //****************************************************************
    // Properties
    //****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // Clock low half lasts exactly four cycles, high half at least four
    a_low_half_len:  assert property ($fell(clk_p) |-> !clk_p [*4] ##1 clk_p)
        else $error("clock low half has wrong length");
    a_high_half_len: assert property ($rose(clk_p) |-> clk_p [*4])
        else $error("clock high half too short");
    a_data_fall_rise: assert property ($fell(data_p) |-> $rose(clk_p))
        else $error("data fell away from a clock rise");
    a_data_rise_high: assert property ($rose(data_p) |-> clk_p)
        else $error("data rose while clock low");
    a_data_hold_low: assert property (!clk_p |-> $stable(data_p))
        else $error("data moved during clock low half");
    a_mono_min_wait: assert property ($rose(data_p) && !$rose(clk_p) |-> hi_cnt >= TM - HALF)
        else $error("data returned high before monoflop time");
    a_mono_max_wait: assert property (hi_cnt == TM + 16 |-> data_p)
        else $error("data stuck low after monoflop time");
    a_restart_gap_ok: assert property ($fell(clk_p) && hi_cnt != HALF |-> data_p || hi_cnt >= TP)
        else $error("burst started while data still low");
endmodule

// ---- sim/tb_ssi_encoder_position_output.sv ----
// Self-checking bench joining encoder and controller over the link
`timescale 1ns/10ps
module tb_ssi_encoder_position_output;
    import ssi_pkg::*;
    //****************************************************************
    // Signals
    //****************************************************************
    localparam int NB       = WORD_BITS;  // Word width n
    localparam int TM_SIM   = 40;         // Short monoflop, keeps runs brief
    localparam int HALF_SIM = 4;          // Short clock half period
    localparam int TP_SIM   = 60;         // Short clock pause
    typedef struct {
        logic [NB-1:0] pos;
        logic          ring;
    } row_t;
    row_t          rows [4];         // Ordinary cases
    logic          sys_clk;          // System clock
    logic          nrst;             // Reset, active low
    logic [NB-1:0] pos_word;         // Position source
    logic          run;              // Burst enable
    logic          ring_mode;        // Double read
    logic          word_ready;       // Pop strobe
    logic          word_valid;
    logic [NB-1:0] word_data;
    logic          word_mismatch;
    logic          busy;
    logic          mono_busy;
    logic [NB:0]   shreg;            // Bits seen on the wire
    int            nrise;            // Clock rises in frame
    int            err_total;
    int            n_compared;

    //****************************************************************
    // Design
    //****************************************************************
    ssi_link_if i_ssi_link_if ();
    ssi_encoder #(.N_BITS(NB), .TM(TM_SIM)) i_ssi_encoder (
        .link(i_ssi_link_if.device), .sys_clk(sys_clk), .nrst(nrst),
        .pos_word(pos_word), .mono_busy(mono_busy));
    ssi_controller #(
        .N_BITS(NB), .HALF(HALF_SIM), .TP(TP_SIM), .DEPTH(FIFO_DEPTH)
    ) i_ssi_controller (
        .link(i_ssi_link_if.ctrl), .sys_clk(sys_clk), .nrst(nrst), .run(run),
        .ring_mode(ring_mode), .word_valid(word_valid), .word_ready(word_ready),
        .word_data(word_data), .word_mismatch(word_mismatch), .busy(busy));
    ssi_link_sva #(.TM(TM_SIM), .HALF(HALF_SIM), .TP(TP_SIM)) i_ssi_link_sva (
        .sys_clk(sys_clk), .nrst(nrst), .clk_p(i_ssi_link_if.clk_p),
        .data_p(i_ssi_link_if.data_p));

    // Clock, 40 ns period
    always #20 sys_clk = ~sys_clk;

    // Wire monitor: shift in data just after each link clock rise
    always @(posedge i_ssi_link_if.clk_p) begin
        #1 shreg = {shreg[NB-1:0], i_ssi_link_if.data_p};
        nrise = nrise + 1;
    end

    //****************************************************************
    // Tasks
    //****************************************************************
    task automatic tick();
        @(posedge sys_clk);
        #2;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Bounded wait: 0 busy, 1 word_valid, 2 link idle with monoflop done
    task automatic wait_for(input int which, input logic v);
        int k;
        logic s;
        for (k = 0; k < 3000; k++) begin
            s = (which == 0) ? busy : (which == 1) ? word_valid
                : (!mono_busy && i_ssi_link_if.data_p);
            if (s === v) begin
                return;
            end
            tick();
        end
        err_total++;
        report_and_stop();
    endtask

    //****************************************************************
    // Main sequence
    //****************************************************************
    initial begin
        rows[0] = '{25'h1ff_ffff, 1'b0};
        rows[1] = '{25'h155_5555, 1'b1};
        rows[2] = '{25'h000_0001, 1'b0};
        rows[3] = '{25'h0aa_aaaa, 1'b1};
        sys_clk = 1'b0;
        nrst = 1'b0;
        pos_word = rows[0].pos;
        run = 1'b0;
        ring_mode = 1'b0;
        word_ready = 1'b0;
        shreg = '0;
        nrise = 0;
        err_total = 0;
        n_compared = 0;
        repeat (16) tick();
        // Reset idle levels
        check({busy, word_valid, mono_busy}, 32'h0000_0000);
        check({i_ssi_link_if.clk_p, i_ssi_link_if.data_p}, 32'h0000_0003);
        nrst = 1'b1;
        for (int i = 0; i < 4; i++) begin
            repeat (8) tick();
            wait_for(2, 1'b1);
            // Lines rest high between frames
            check({i_ssi_link_if.clk_p, i_ssi_link_if.data_p}, 32'h0000_0003);
            ring_mode = rows[i].ring;
            nrise = 0;
            run = 1'b1;
            wait_for(0, 1'b1);
            run = 1'b0;
            // Later source changes must not reach this frame
            pos_word = ~rows[i].pos;
            wait_for(1, 1'b1);
            // Monoflop running, data held low after the word
            check(mono_busy, 1'b1);
            check(i_ssi_link_if.data_p, 1'b0);
            // Next word must be in place before the monoflop expires
            pos_word = (i < 3) ? rows[i + 1].pos : 25'h0f0_f0f0;
            wait_for(0, 1'b0);
            if (!rows[i].ring) begin
                // MSB first, n bits, then low separator
                check(nrise, NB + 1);
                check(shreg, {rows[i].pos, 1'b0});
            end
            // Fresh word after the pause, ring copies agree
            check(word_data, rows[i].pos);
            check(word_mismatch, 1'b0);
            word_ready = 1'b1;
            tick();
            word_ready = 1'b0;
            tick();
            check(word_valid, 1'b0);
        end
        // Back-pressure: fill the FIFO with the consumer stalled
        ring_mode = 1'b0;
        pos_word = 25'h0f0_f0f0;
        wait_for(2, 1'b1);
        repeat (4) tick();
        wait_for(2, 1'b1);
        run = 1'b1;
        repeat (2500) tick();
        check(busy, 1'b0);
        run = 1'b0;
        // Pop strobe held high for four back-to-back pops
        word_ready = 1'b1;
        for (int k = 0; k < 4; k++) begin
            check(word_valid, 1'b1);
            check(word_data, 25'h0f0_f0f0);
            tick();
        end
        word_ready = 1'b0;
        check(word_valid, 1'b0);
        // Reset in mid-frame: lines back high, fresh word afterwards
        pos_word = 25'h123_4567;
        wait_for(2, 1'b1);
        run = 1'b1;
        wait_for(0, 1'b1);
        run = 1'b0;
        repeat (20) tick();
        nrst = 1'b0;
        tick();
        check({i_ssi_link_if.clk_p, i_ssi_link_if.data_p}, 32'h0000_0003);
        check({busy, word_valid, mono_busy}, 32'h0000_0000);
        nrst = 1'b1;
        repeat (8) tick();
        run = 1'b1;
        wait_for(0, 1'b1);
        run = 1'b0;
        wait_for(1, 1'b1);
        check(word_data, 25'h123_4567);
        report_and_stop();
    end
endmodule
